/* File: bench/iao_veh_model.sv */
`timescale 1ns/100ps
// stands in for the vehicle: sensors and switches change only after an edge
module iao_veh_model (
  input wire logic clock_in,
  input wire logic [21:0] scene_in,
  output logic switch_a_out,
  output logic switch_b_out,
  output logic park_out,
  output logic door_out,
  output logic takeoff_out,
  output logic engine_out,
  output logic moving_out,
  output logic [6:0] speed_out,
  output logic [7:0] gear_out
);
  logic [21:0] pins_r = 22'h0;
  always @(posedge clock_in) begin
    pins_r <= scene_in;
  end
  assign {switch_a_out, switch_b_out, park_out} = pins_r[21:19];
  assign {door_out, takeoff_out} = pins_r[18:17];
  assign {engine_out, moving_out, speed_out, gear_out} = pins_r[16:0];
endmodule // iao_veh_model

/* File: bench/tb.sv */
`timescale 1ns/100ps
module tb;
  import iao_pkg::*;
  logic clock_in = 0, reset_n_in = 0, psel = 0, penable = 0, pwrite = 0;
  logic chk_en = 0, sw_a = 0, sw_b = 0, park = 0, door = 0, takeoff = 0;
  logic eng = 0, mov = 0, s_a, s_b, p_pk, p_dr, p_pt, p_en, p_mv;
  logic [6:0] spd = 7'h00, p_sp, ta, tb_;
  logic [7:0] gear = 8'h00, p_gr, ga, gb;
  logic [4:0] sa, sb;
  logic [11:0] paddr = 12'h000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, aux_a, aux_b;
  logic [32:0] rq[$];
  logic [1:0] aq[$];
  int err_count = 0, cmp_count = 0, seed;
  always #2.5 clock_in = ~clock_in;
  iao_veh_model iao_veh_model_i (.clock_in(clock_in),
    .scene_in({sw_a, sw_b, park, door, takeoff, eng, mov, spd, gear}),
    .switch_a_out(s_a), .switch_b_out(s_b), .park_out(p_pk),
    .door_out(p_dr), .takeoff_out(p_pt), .engine_out(p_en),
    .moving_out(p_mv), .speed_out(p_sp), .gear_out(p_gr));
  iao_top iao_top_i (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .switch_a_in(s_a), .switch_b_in(s_b), .park_brake_in(p_pk),
    .door_open_in(p_dr), .power_take_off_in(p_pt), .engine_run_in(p_en),
    .moving_in(p_mv), .speed_mph_in(p_sp), .gear_code_in(p_gr),
    .aux_a_out(aux_a), .aux_b_out(aux_b));
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // checker side: compares whatever result shows up with the oldest note
  always @(posedge clock_in) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (rq.size() == 0) cmp(33'h1ffffffff, 33'h0);
      else cmp({pslverr, prdata}, rq.pop_front());
    end
    if (chk_en) begin
      if (aq.size() == 0) cmp(33'h3, 33'h0);
      else cmp({31'h0, aux_b, aux_a}, {31'h0, aq.pop_front()});
    end
  end
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int n;
    @(posedge clock_in);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) rq.push_back(e);
    @(posedge clock_in);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      $display("wrong value at %0t: no ready from the slave", $time);
      end_sim();
    end
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  // allow pin sync latency to settle before sampling the loads
  task automatic chk(input logic ea, input logic eb);
    repeat (5) @(posedge clock_in);
    aq.push_back({eb, ea});
    chk_en <= 1;
    @(posedge clock_in);
    chk_en <= 0;
  endtask
  function automatic logic want(input logic [4:0] s, input logic w,
                                input logic [6:0] st, input logic [7:0] gt);
    logic c;
    case (s)
      5'h00: c = 1'b1;
      5'h01: c = park;
      5'h02: c = !park;
      5'h03: c = door;
      5'h04: c = !door;
      5'h05: c = takeoff;
      5'h06: c = !takeoff;
      5'h07: c = eng;
      5'h08: c = !eng;
      5'h09: c = spd > st;
      5'h0a: c = spd < st;
      5'h0b: c = !mov;
      5'h0c: c = mov;
      5'h0d: c = gear > gt;
      5'h0e: c = gear < gt;
      5'h0f: c = gear == 8'h7d;
      5'h10: c = gear != 8'h7d;
      default: c = 1'b0;
    endcase
    return w & c;
  endfunction
  initial begin
    repeat (100000) @(posedge clock_in);
    err_count++;
    $display("wrong value at %0t: run timed out", $time);
    end_sim();
  end
  initial begin
    seed = $urandom(32'hdf62);
    repeat (20) @(posedge clock_in);
    reset_n_in <= 1;
    for (int c = 0; c < 2; c++) begin
      paddr <= paddr;
      apb(0, REG_SEL_A + 12'(c * 32), 0, {28'h0, SEL_RESET});
      apb(0, REG_LATCH_A + 12'(c * 32), 0, 33'h0);
      apb(0, REG_SPD_A + 12'(c * 32), 0, {26'h0, SPD_RESET});
      apb(0, REG_GEAR_A + 12'(c * 32), 0, {25'h0, GEAR_RESET});
    end
    wr(REG_SPD_A, 32'd101);
    apb(0, REG_SPD_A, 0, {26'h0, SPD_RESET});
    wr(REG_SPD_A, 32'd100);
    apb(0, REG_SPD_A, 0, 33'd100);
    wr(REG_GEAR_A, 32'd251);
    apb(0, REG_GEAR_A, 0, 33'h0);
    wr(REG_GEAR_A, 32'd250);
    apb(0, REG_GEAR_A, 0, 33'd250);
    apb(0, 12'h040, 0, {1'b1, 32'h0});
    // a write without the low byte lane must leave the setting alone
    pstrb <= 4'h0;
    wr(REG_SEL_B, 32'h1);
    pstrb <= 4'hf;
    apb(0, REG_SEL_B, 0, {28'h0, SEL_RESET});
    $display("test defaults and ranges done");
    for (int s = 0; s < 18; s++) begin
      for (int k = 0; k < 4; k++) begin
        sa = (s == 17) ? 5'(17 + $urandom_range(14)) : 5'(s);
        sb = (s == 17) ? 5'(17 + $urandom_range(14)) : 5'($urandom_range(16));
        ta = 7'($urandom_range(100));
        tb_ = 7'($urandom_range(100));
        ga = 8'($urandom_range(250));
        gb = 8'($urandom_range(250));
        wr(REG_SEL_A, {27'h0, sa});
        wr(REG_SPD_A, {25'h0, ta});
        wr(REG_GEAR_A, {24'h0, ga});
        wr(REG_SEL_B, {27'h0, sb});
        wr(REG_SPD_B, {25'h0, tb_});
        wr(REG_GEAR_B, {24'h0, gb});
        {sw_a, sw_b, park, door, takeoff, eng, mov} <= 7'($urandom);
        spd <= (k == 0) ? ta : 7'($urandom);
        gear <= (k == 1) ? 8'h7d : (k == 2) ? ga : 8'($urandom);
        @(posedge clock_in);
        chk(want(sa, sw_a, ta, ga), want(sb, sw_b, tb_, gb));
      end
    end
    $display("test selections done");
    wr(REG_LATCH_A, 32'h1);
    wr(REG_SEL_A, {27'h0, SEL_ENG_RUN});
    wr(REG_SEL_B, {27'h0, SEL_ENG_RUN});
    {sw_a, sw_b, eng} <= 3'h7;
    chk(1'b1, 1'b1);
    eng <= 0;
    chk(1'b0, 1'b0);
    eng <= 1;
    chk(1'b0, 1'b1);
    apb(0, REG_STAT_A, 0, 33'h6);
    sw_a <= 0;
    chk(1'b0, 1'b1);
    sw_a <= 1;
    chk(1'b1, 1'b1);
    $display("test latch-off done");
    // lock channel a again, then reset in mid-run must clear the lock
    eng <= 0;
    spd <= 7'h00;
    chk(1'b0, 1'b0);
    reset_n_in <= 0;
    repeat (3) @(posedge clock_in);
    reset_n_in <= 1;
    chk(1'b1, 1'b1);
    apb(0, REG_STAT_A, 0, 33'h5);
    apb(0, REG_LATCH_A, 0, 33'h0);
    $display("test reset in mid-run done");
    end_sim();
  end
endmodule // tb

/* File: hw/iao_top.sv */
`timescale 1ns/100ps
module iao_top (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [iao_pkg::APB_AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic switch_a_in,
  input wire logic switch_b_in,
  input wire logic park_brake_in,
  input wire logic door_open_in,
  input wire logic power_take_off_in,
  input wire logic engine_run_in,
  input wire logic moving_in,
  input wire logic [iao_pkg::SPD_W-1:0] speed_mph_in,
  input wire logic [iao_pkg::GEAR_W-1:0] gear_code_in,
  output logic aux_a_out,
  output logic aux_b_out
);
  import iao_pkg::*;

  localparam int NCH = 2;
  localparam int NVEH = 5;

  typedef struct packed {
    logic [NCH-1:0][SEL_W-1:0] sel;
    logic [NCH-1:0] latch_en;
    logic [NCH-1:0][SPD_W-1:0] spd;
    logic [NCH-1:0][GEAR_W-1:0] gear;
    logic [NCH-1:0] out;
    logic [NCH-1:0] locked;
    logic [NCH-1:0] cond;
    logic [NCH-1:0][1:0] sw_sync;
    logic [NVEH-1:0][1:0] veh_sync;
    logic [1:0][SPD_W-1:0] spd_sync;
    logic [1:0][GEAR_W-1:0] gear_sync;
    logic [31:0] rdata;
  } iao_state_t;

  iao_state_t st_r;
  iao_state_t st_nxt;

  logic [NCH-1:0] sw;
  logic park_s, door_s, takeoff_s, eng_s, mov_s;
  logic [SPD_W-1:0] spd_s;
  logic [GEAR_W-1:0] gear_s;
  logic [NCH-1:0] cond_now;
  logic access;
  logic wr;
  logic [APB_AW-1:0] base;
  logic chan;
  logic mapped;

  // pins are asynchronous to the clock; only stage two is read.
  // multi-bit speed/gear may tear for a cycle; harmless, sampled again next
  assign sw = {st_r.sw_sync[1][1], st_r.sw_sync[0][1]};
  assign park_s = st_r.veh_sync[0][1];
  assign door_s = st_r.veh_sync[1][1];
  assign takeoff_s = st_r.veh_sync[2][1];
  assign eng_s = st_r.veh_sync[3][1];
  assign mov_s = st_r.veh_sync[4][1];
  assign spd_s = st_r.spd_sync[1];
  assign gear_s = st_r.gear_sync[1];

  // condition per channel from its own settings only
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      unique case (st_r.sel[c])
        SEL_NONE: cond_now[c] = 1'b1;
        SEL_PARK_SET: cond_now[c] = park_s;
        SEL_PARK_OFF: cond_now[c] = !park_s;
        SEL_DOOR_OPEN: cond_now[c] = door_s;
        SEL_DOOR_SHUT: cond_now[c] = !door_s;
        SEL_TAKEOFF_ON: cond_now[c] = takeoff_s;
        SEL_TAKEOFF_OFF: cond_now[c] = !takeoff_s;
        SEL_ENG_RUN: cond_now[c] = eng_s;
        SEL_ENG_STOP: cond_now[c] = !eng_s;
        SEL_SPD_ABOVE: cond_now[c] = spd_s > st_r.spd[c];
        SEL_SPD_BELOW: cond_now[c] = spd_s < st_r.spd[c];
        SEL_STOPPED: cond_now[c] = !mov_s;
        SEL_MOVING: cond_now[c] = mov_s;
        SEL_GEAR_ABOVE: cond_now[c] = gear_s > st_r.gear[c];
        SEL_GEAR_BELOW: cond_now[c] = gear_s < st_r.gear[c];
        SEL_NEUTRAL: cond_now[c] = gear_s == GEAR_NEUTRAL;
        SEL_NOT_NEUTRAL: cond_now[c] = gear_s != GEAR_NEUTRAL;
        default: cond_now[c] = 1'b0;
      endcase
    end
  end

  assign access = psel_in && penable_in;
  assign wr = access && pwrite_in;
  assign chan = paddr_in[CHAN_BIT];
  assign base = paddr_in & ~REG_SEL_B;
  assign mapped = (paddr_in[APB_AW-1:BLOCK_BITS] == '0)
    && (paddr_in[ALIGN_BITS-1:0] == '0) && (base <= REG_STAT_A);

  always_comb begin
    st_nxt = st_r;
    for (int c = 0; c < NCH; c++) begin
      st_nxt.sw_sync[c] = {st_r.sw_sync[c][0], c == 0 ? switch_a_in
        : switch_b_in};
    end
    st_nxt.veh_sync[0] = {st_r.veh_sync[0][0], park_brake_in};
    st_nxt.veh_sync[1] = {st_r.veh_sync[1][0], door_open_in};
    st_nxt.veh_sync[2] = {st_r.veh_sync[2][0], power_take_off_in};
    st_nxt.veh_sync[3] = {st_r.veh_sync[3][0], engine_run_in};
    st_nxt.veh_sync[4] = {st_r.veh_sync[4][0], moving_in};
    st_nxt.spd_sync = {st_r.spd_sync[0], speed_mph_in};
    st_nxt.gear_sync = {st_r.gear_sync[0], gear_code_in};

    for (int c = 0; c < NCH; c++) begin
      st_nxt.cond[c] = cond_now[c];
      // lock only when a live output is dropped by its interlock
      // a lock never outlives latch-off itself being turned off
      if (!sw[c] || !st_r.latch_en[c]) begin
        st_nxt.locked[c] = 1'b0;
      end else if (st_r.latch_en[c] && st_r.out[c] && !cond_now[c]) begin
        st_nxt.locked[c] = 1'b1;
      end
      st_nxt.out[c] = sw[c] && cond_now[c] && !st_nxt.locked[c];
    end

    // writes take the low byte lane; out-of-range speed and gear thresholds are refused
    if (wr && mapped && pstrb_in[0]) begin
      unique case (base)
        REG_SEL_A: st_nxt.sel[chan] = pwdata_in[SEL_W-1:0];
        REG_LATCH_A: st_nxt.latch_en[chan] = pwdata_in[0];
        REG_SPD_A: begin
          if (pwdata_in[31:SPD_W] == '0 && pwdata_in[SPD_W-1:0] <= SPD_MAX)
            st_nxt.spd[chan] = pwdata_in[SPD_W-1:0];
        end
        REG_GEAR_A: begin
          if (pwdata_in[31:GEAR_W] == '0
              && pwdata_in[GEAR_W-1:0] <= GEAR_MAX)
            st_nxt.gear[chan] = pwdata_in[GEAR_W-1:0];
        end
        default: ;
      endcase
    end

    st_nxt.rdata = '0;
    if (psel_in && !penable_in && !pwrite_in && mapped) begin
      unique case (base)
        REG_SEL_A: st_nxt.rdata[SEL_W-1:0] = st_r.sel[chan];
        REG_LATCH_A: st_nxt.rdata[0] = st_r.latch_en[chan];
        REG_SPD_A: st_nxt.rdata[SPD_W-1:0] = st_r.spd[chan];
        REG_GEAR_A: st_nxt.rdata[GEAR_W-1:0] = st_r.gear[chan];
        REG_STAT_A: begin
          st_nxt.rdata[STAT_OUT_BIT] = st_r.out[chan];
          st_nxt.rdata[STAT_LOCK_BIT] = st_r.locked[chan];
          st_nxt.rdata[STAT_COND_BIT] = st_r.cond[chan];
        end
        default: ;
      endcase
    end

    if (!reset_n_in) begin
      st_nxt = '0;
      for (int c = 0; c < NCH; c++) begin
        st_nxt.sel[c] = SEL_RESET;
        st_nxt.spd[c] = SPD_RESET;
        st_nxt.gear[c] = GEAR_RESET;
      end
      st_nxt.latch_en = '0;
      st_nxt.locked = '0;
    end
  end

  always_ff @(posedge clock_in) begin
    st_r <= st_nxt;
  end

  assign aux_a_out = st_r.out[0];
  assign aux_b_out = st_r.out[1];
  assign prdata_out = st_r.rdata;
  assign pready_out = 1'b1;
  assign pslverr_out = access && !mapped;

  // assertions
  property p_zero_follows_switch;
    @(posedge clock_in) disable iff (!reset_n_in)
    (st_r.sel[0] == SEL_NONE && $stable(st_r.sel[0]) && !st_r.locked[0])
      |=> (aux_a_out == $past(sw[0]));
  endproperty
  a_zero_follows_switch: assert property (p_zero_follows_switch)
    else $error("selection zero output does not follow switch");

  property p_park_set;
    @(posedge clock_in) disable iff (!reset_n_in)
    (st_r.sel[0] == SEL_PARK_SET && !park_s) |=> !aux_a_out;
  endproperty
  a_park_set: assert property (p_park_set)
    else $error("output on with park brake released");

  property p_door_shut;
    @(posedge clock_in) disable iff (!reset_n_in)
    (st_r.sel[1] == SEL_DOOR_SHUT && door_s) |=> !aux_b_out;
  endproperty
  a_door_shut: assert property (p_door_shut)
    else $error("output on with a door open");

  property p_speed_above;
    @(posedge clock_in) disable iff (!reset_n_in)
    (st_r.sel[0] == SEL_SPD_ABOVE && spd_s <= st_r.spd[0]) |=> !aux_a_out;
  endproperty
  a_speed_above: assert property (p_speed_above)
    else $error("output on at or below speed threshold");

  property p_gear_below;
    @(posedge clock_in) disable iff (!reset_n_in)
    (st_r.sel[0] == SEL_GEAR_BELOW && sw[0] && !st_r.locked[0]
      && gear_s < st_r.gear[0] && !st_r.latch_en[0]) |=> aux_a_out;
  endproperty
  a_gear_below: assert property (p_gear_below)
    else $error("output off with gear below threshold");

  property p_no_latch_return;
    @(posedge clock_in) disable iff (!reset_n_in)
    (!st_r.latch_en[0] && sw[0] && cond_now[0]) |=> aux_a_out;
  endproperty
  a_no_latch_return: assert property (p_no_latch_return)
    else $error("output did not return without latch-off");

  property p_latch_holds;
    @(posedge clock_in) disable iff (!reset_n_in)
    (st_r.latch_en[0] && aux_a_out && sw[0] && !cond_now[0]
      && $stable(st_r.latch_en[0]))
      ##1 (sw[0] && st_r.latch_en[0])[*2] |=> !aux_a_out;
  endproperty
  a_latch_holds: assert property (p_latch_holds)
    else $error("latched output came back without switch cycle");

  property p_bad_sel;
    @(posedge clock_in) disable iff (!reset_n_in)
    (st_r.sel[1] > SEL_NOT_NEUTRAL) |=> !aux_b_out;
  endproperty
  a_bad_sel: assert property (p_bad_sel)
    else $error("output on with illegal selection");

  property p_reset_defaults;
    @(posedge clock_in)
    !reset_n_in |=> (st_r.sel[0] == SEL_RESET && st_r.spd[1] == SPD_RESET
      && st_r.gear[0] == GEAR_RESET && st_r.locked == '0);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("settings not at defaults after reset");

  property p_park_off;
    @(posedge clock_in) disable iff (!reset_n_in)
    (st_r.sel[1] == SEL_PARK_OFF && park_s) |=> !aux_b_out;
  endproperty
  a_park_off: assert property (p_park_off)
    else $error("output on with park brake set");

  property p_door_open;
    @(posedge clock_in) disable iff (!reset_n_in)
    (st_r.sel[0] == SEL_DOOR_OPEN && !door_s) |=> !aux_a_out;
  endproperty
  a_door_open: assert property (p_door_open)
    else $error("output on with all doors closed");

  property p_takeoff_on;
    @(posedge clock_in) disable iff (!reset_n_in)
    (st_r.sel[0] == SEL_TAKEOFF_ON && !takeoff_s) |=> !aux_a_out;
  endproperty
  a_takeoff_on: assert property (p_takeoff_on)
    else $error("output on with power take-off not engaged");

  property p_takeoff_off;
    @(posedge clock_in) disable iff (!reset_n_in)
    (st_r.sel[1] == SEL_TAKEOFF_OFF && takeoff_s) |=> !aux_b_out;
  endproperty
  a_takeoff_off: assert property (p_takeoff_off)
    else $error("output on with power take-off engaged");

  property p_eng_run;
    @(posedge clock_in) disable iff (!reset_n_in)
    (st_r.sel[1] == SEL_ENG_RUN && !eng_s) |=> !aux_b_out;
  endproperty
  a_eng_run: assert property (p_eng_run)
    else $error("output on with engine stopped");

  property p_eng_stop;
    @(posedge clock_in) disable iff (!reset_n_in)
    (st_r.sel[0] == SEL_ENG_STOP && eng_s) |=> !aux_a_out;
  endproperty
  a_eng_stop: assert property (p_eng_stop)
    else $error("output on with engine running");

  property p_speed_below;
    @(posedge clock_in) disable iff (!reset_n_in)
    (st_r.sel[1] == SEL_SPD_BELOW && spd_s >= st_r.spd[1]) |=> !aux_b_out;
  endproperty
  a_speed_below: assert property (p_speed_below)
    else $error("output on at or above speed threshold");

  property p_stopped;
    @(posedge clock_in) disable iff (!reset_n_in)
    (st_r.sel[0] == SEL_STOPPED && mov_s) |=> !aux_a_out;
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("output on while vehicle moving");

  property p_moving;
    @(posedge clock_in) disable iff (!reset_n_in)
    (st_r.sel[1] == SEL_MOVING && !mov_s) |=> !aux_b_out;
  endproperty
  a_moving: assert property (p_moving)
    else $error("output on while vehicle stopped");

  property p_gear_above;
    @(posedge clock_in) disable iff (!reset_n_in)
    (st_r.sel[1] == SEL_GEAR_ABOVE && gear_s <= st_r.gear[1]) |=> !aux_b_out;
  endproperty
  a_gear_above: assert property (p_gear_above)
    else $error("output on with gear not above threshold");

  property p_neutral;
    @(posedge clock_in) disable iff (!reset_n_in)
    (st_r.sel[0] == SEL_NEUTRAL && gear_s != GEAR_NEUTRAL) |=> !aux_a_out;
  endproperty
  a_neutral: assert property (p_neutral)
    else $error("output on out of neutral");

  property p_not_neutral;
    @(posedge clock_in) disable iff (!reset_n_in)
    (st_r.sel[1] == SEL_NOT_NEUTRAL && gear_s == GEAR_NEUTRAL) |=> !aux_b_out;
  endproperty
  a_not_neutral: assert property (p_not_neutral)
    else $error("output on in neutral");

  property p_zero_b;
    @(posedge clock_in) disable iff (!reset_n_in)
    (st_r.sel[1] == SEL_NONE && sw[1] && !st_r.locked[1]) |=> aux_b_out;
  endproperty
  a_zero_b: assert property (p_zero_b)
    else $error("output off with no interlock and switch on");

  property p_switch_off_a;
    @(posedge clock_in) disable iff (!reset_n_in)
    !sw[0] |=> (!aux_a_out && !st_r.locked[0]);
  endproperty
  a_switch_off_a: assert property (p_switch_off_a)
    else $error("output or lock survives switch off");

  property p_switch_off_b;
    @(posedge clock_in) disable iff (!reset_n_in)
    !sw[1] |=> (!aux_b_out && !st_r.locked[1]);
  endproperty
  a_switch_off_b: assert property (p_switch_off_b)
    else $error("second output or lock survives its switch off");

  property p_speed_range;
    @(posedge clock_in) disable iff (!reset_n_in)
    st_r.spd[0] <= SPD_MAX && st_r.spd[1] <= SPD_MAX;
  endproperty
  a_speed_range: assert property (p_speed_range)
    else $error("speed threshold outside its range");

  property p_gear_range;
    @(posedge clock_in) disable iff (!reset_n_in)
    st_r.gear[0] <= GEAR_MAX && st_r.gear[1] <= GEAR_MAX;
  endproperty
  a_gear_range: assert property (p_gear_range)
    else $error("gear threshold outside its range");

  property p_latch_default;
    @(posedge clock_in)
    !reset_n_in |=> (st_r.latch_en == '0 && st_r.out == '0);
  endproperty
  a_latch_default: assert property (p_latch_default)
    else $error("latch-off or output not off after reset");

endmodule // iao_top

/* File: inc/iao_pkg.sv */
// Operation
// - selection zero: output follows the switch alone
// - selection 1 park brake set, 2 park brake released, with switch on
// - selection 3 any door open, 4 all doors closed, with switch on
// - selection 5 power take-off engaged, 6 not engaged, with switch on
// - selection 7 engine running, 8 engine not running, with switch on
// - selection 9 speed above threshold, 10 speed below threshold
// - selection 11 vehicle stopped, 12 vehicle moving, with switch on
// - selection 13 gear code above threshold, 14 below threshold
// - selection 15 transmission in neutral, 16 out of neutral
// - latch-off disabled: output returns when condition returns, switch on
// - latch-off enabled: dropped output stays off until switch cycles
// - speed threshold in mph consulted only for selections 9 and 10
// - gear code: neutral 125, forward x is 125+x, reverse y 125-y
// - gear threshold consulted only for selections 13 and 14
// - speed threshold defaults to 30, range 0 to 100
// - gear threshold defaults to 0, range 0 to 250
// - interlock selection defaults to 10 after reset
// - on/off settings: 0 off, 1 on; latch-off defaults off
// - two fully independent outputs, each with private settings
package iao_pkg;
  localparam int SEL_W = 5;
  localparam int SPD_W = 7;
  localparam int GEAR_W = 8;
  localparam int APB_AW = 12;
  localparam logic [SEL_W-1:0] SEL_NONE = 5'h00;
  localparam logic [SEL_W-1:0] SEL_PARK_SET = 5'h01;
  localparam logic [SEL_W-1:0] SEL_PARK_OFF = 5'h02;
  localparam logic [SEL_W-1:0] SEL_DOOR_OPEN = 5'h03;
  localparam logic [SEL_W-1:0] SEL_DOOR_SHUT = 5'h04;
  localparam logic [SEL_W-1:0] SEL_TAKEOFF_ON = 5'h05;
  localparam logic [SEL_W-1:0] SEL_TAKEOFF_OFF = 5'h06;
  localparam logic [SEL_W-1:0] SEL_ENG_RUN = 5'h07;
  localparam logic [SEL_W-1:0] SEL_ENG_STOP = 5'h08;
  localparam logic [SEL_W-1:0] SEL_SPD_ABOVE = 5'h09;
  localparam logic [SEL_W-1:0] SEL_SPD_BELOW = 5'h0a;
  localparam logic [SEL_W-1:0] SEL_STOPPED = 5'h0b;
  localparam logic [SEL_W-1:0] SEL_MOVING = 5'h0c;
  localparam logic [SEL_W-1:0] SEL_GEAR_ABOVE = 5'h0d;
  localparam logic [SEL_W-1:0] SEL_GEAR_BELOW = 5'h0e;
  localparam logic [SEL_W-1:0] SEL_NEUTRAL = 5'h0f;
  localparam logic [SEL_W-1:0] SEL_NOT_NEUTRAL = 5'h10;
  localparam logic [SEL_W-1:0] SEL_RESET = 5'h0a;
  localparam logic [SPD_W-1:0] SPD_RESET = 7'h1e;
  localparam logic [SPD_W-1:0] SPD_MAX = 7'h64;
  localparam logic [GEAR_W-1:0] GEAR_RESET = 8'h00;
  localparam logic [GEAR_W-1:0] GEAR_MAX = 8'hfa;
  localparam logic [GEAR_W-1:0] GEAR_NEUTRAL = 8'h7d;
  // register byte addresses; channel b sits 0x20 above channel a
  localparam logic [APB_AW-1:0] REG_SEL_A = 12'h000;
  localparam logic [APB_AW-1:0] REG_LATCH_A = 12'h004;
  localparam logic [APB_AW-1:0] REG_SPD_A = 12'h008;
  localparam logic [APB_AW-1:0] REG_GEAR_A = 12'h00c;
  localparam logic [APB_AW-1:0] REG_STAT_A = 12'h010;
  localparam logic [APB_AW-1:0] REG_SEL_B = 12'h020;
  localparam logic [APB_AW-1:0] REG_LATCH_B = 12'h024;
  localparam logic [APB_AW-1:0] REG_SPD_B = 12'h028;
  localparam logic [APB_AW-1:0] REG_GEAR_B = 12'h02c;
  localparam logic [APB_AW-1:0] REG_STAT_B = 12'h030;
  localparam int STAT_OUT_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam int STAT_COND_BIT = 2;
  localparam int CHAN_BIT = 5;
  localparam int BLOCK_BITS = 6;
  localparam int ALIGN_BITS = 2;
endpackage
